/* rtl/tcc_chan_if.sv */
// Per-channel link between the register core and an edge detector
`timescale 1ns/10ps
interface tcc_chan_if;
    logic       raw;
    logic       filt_en;
    logic [1:0] edge_sel;
    logic       strobe;
    modport det (input raw, input filt_en, input edge_sel, output strobe);
    modport ctl (output raw, output filt_en, output edge_sel, input strobe);
endinterface

/* rtl/tcc_edge.sv */
// Input synchroniser, glitch filter and edge detector for one channel
`timescale 1ns/10ps
module tcc_edge (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    tcc_chan_if.det   ch
);
    import tcc_pkg::*;
    localparam int unsigned RUN_W = $clog2(FILT_CLKS);
    typedef struct packed {
        logic             s1;
        logic             s2;
        logic             filt;
        logic             prev;
        logic [RUN_W-1:0] run;
    } tcc_edge_st_t;
    tcc_edge_st_t st_q;
    tcc_edge_st_t st_d;
    logic         level;

    if (FILT_CLKS < 2)
    begin : g_chk
        $error("Filter length below two clocks is not supported");
    end

    always_comb
    begin
        st_d = st_q;
        st_d.s1 = ch.raw;
        st_d.s2 = st_q.s1;
        // New level is taken only after it held for the full filter length
        if (st_q.s2 == st_q.filt)
            st_d.run = '0;
        else if (st_q.run == RUN_W'(FILT_CLKS - 1))
        begin
            st_d.filt = st_q.s2;
            st_d.run  = '0;
        end
        else
            st_d.run = st_q.run + 1'b1;
        level = ch.filt_en ? st_q.filt : st_q.s2;
        st_d.prev = level;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    always_comb
    begin
        case (tcc_edge_t'(ch.edge_sel))
            TCC_EDGE_FALL: ch.strobe = ~level & st_q.prev;
            TCC_EDGE_RISE: ch.strobe = level & ~st_q.prev;
            TCC_EDGE_BOTH: ch.strobe = level ^ st_q.prev;
            default:       ch.strobe = 1'b0;
        endcase
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    filter_hold_a: assert property ($changed(st_q.filt) |->
        $past(st_q.s2, 1) == st_q.filt && $past(st_q.s2, 2) == st_q.filt &&
        $past(st_q.s2, 3) == st_q.filt && $past(st_q.s2, 4) == st_q.filt)
        else $error("Filtered level changed before four stable samples");
    reserved_edge_a: assert property (
        ch.edge_sel == TCC_EDGE_RSVD |-> !ch.strobe)
        else $error("Strobe with reserved edge code");
    filt_cov: cover property (ch.filt_en && ch.strobe);
endmodule

/* rtl/tcc_pkg.sv */
// Shared constants and types for the timer capture, reload and compare block
package tcc_pkg;
    localparam int unsigned APB_DW   = 32;
    localparam int unsigned NCH      = 3;
    localparam int unsigned NPIN     = 2;
    localparam int unsigned CNT_W    = 16;
    localparam int unsigned FILT_CLKS = 4;
    localparam int unsigned DIV_MIN_LOG2 = 2;
    localparam int unsigned DIV_W    = 9;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CAP_CTRL = 8'h92;
    localparam logic [7:0] IDX_EDGE_SEL = 8'h93;
    localparam logic [7:0] IDX_FILT     = 8'h94;
    localparam logic [7:0] IDX_GIE      = 8'hA8;
    localparam logic [7:0] IDX_TCTRL    = 8'hC8;
    localparam logic [7:0] IDX_TMODE    = 8'hC9;
    localparam logic [7:0] IDX_RLD_LO   = 8'hCA;
    localparam logic [7:0] IDX_RLD_HI   = 8'hCB;
    localparam logic [7:0] IDX_CNT_LO   = 8'hCC;
    localparam logic [7:0] IDX_CNT_HI   = 8'hCD;
    localparam logic [7:0] IDX_RES0_LO  = 8'hE4;
    localparam logic [7:0] IDX_RES0_HI  = 8'hE5;
    localparam logic [7:0] IDX_RES1_LO  = 8'hE6;
    localparam logic [7:0] IDX_RES1_HI  = 8'hE7;
    localparam logic [7:0] IDX_IRQ_EN   = 8'hE8;
    localparam logic [7:0] IDX_RES2_LO  = 8'hED;
    localparam logic [7:0] IDX_RES2_HI  = 8'hEE;
    // Field positions
    localparam int unsigned CC_FLAG_LSB = 0;
    localparam int unsigned CC_EN_LSB   = 4;
    localparam int unsigned ES_LSB      = 0;
    localparam int unsigned FC_FEN_LSB  = 4;
    localparam int unsigned TC_CRS_BIT  = 0;
    localparam int unsigned TC_RUN_BIT  = 2;
    localparam int unsigned TC_CMF_BIT  = 7;
    localparam int unsigned TM_LTS_LSB  = 0;
    localparam int unsigned TM_MAC_BIT  = 2;
    localparam int unsigned TM_CAC_BIT  = 3;
    localparam int unsigned TM_DIV_LSB  = 4;
    localparam int unsigned TM_LEN_BIT  = 7;
    localparam int unsigned IE_CPT_BIT  = 2;
    localparam int unsigned GE_EA_BIT   = 7;
    typedef enum logic [1:0] {
        TCC_EDGE_FALL = 2'h0,
        TCC_EDGE_RISE = 2'h1,
        TCC_EDGE_BOTH = 2'h2,
        TCC_EDGE_RSVD = 2'h3
    } tcc_edge_t;
    typedef enum logic [1:0] {
        TCC_RLD_OVF = 2'h0,
        TCC_RLD_CH0 = 2'h1,
        TCC_RLD_CH1 = 2'h2,
        TCC_RLD_CH2 = 2'h3
    } tcc_rld_t;
endpackage

/* rtl/tcc_prescale.sv */
// Timer advance prescaler, divide by 4 to 512
`timescale 1ns/10ps
module tcc_prescale (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       run_i,
    input  wire logic [2:0] div_code_i,
    output logic            tick_o
);
    import tcc_pkg::*;
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
    } tcc_ps_st_t;
    tcc_ps_st_t     st_q;
    tcc_ps_st_t     st_d;
    logic [DIV_W:0] lim;

    always_comb
    begin
        st_d = st_q;
        // Shift amount is four bits so code 7 reaches 512 without wrapping
        lim = (DIV_W + 1)'(1) << (4'(div_code_i) + 4'(DIV_MIN_LOG2));
        tick_o = run_i && ({1'b0, st_q.cnt} >= lim - 1'b1);
        // Halted prescaler keeps its phase, like the count itself
        if (tick_o)
            st_d.cnt = '0;
        else if (run_i)
            st_d.cnt = st_q.cnt + 1'b1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    tick_space_a: assert property (tick_o |=> !tick_o [*3])
        else $error("Timer ticks closer than four clocks");
endmodule

/* rtl/tcc_top.sv */
// Timer capture, auto-reload and compare block with APB register access
//
// Operation
// - Capture mode is selected when compare select is clear, whether or not reload enable is set
// - Three result channels share one 16-bit timer; two pins with detectors
// - Filter enable bits 5:4 reject input pulses shorter than four clocks
// - Edge code 00 falling, 01 rising, 10 both, 11 never triggers
// - A channel captures only while its enable bit (4 or 5) is set
// - Selected edge copies the running count into that channel's result
// - Capture edge sets channel flag bit 0 or 1; software clears it
// - Shared interrupt when a flag, capture enable and global enable are set
// - Capture auto-clear zeroes the count right after the value is stored
// - Auto-reload mode loads the reload pair into the count on reload event
// - Reload event is overflow or one enabled capture channel, by select
// - With capture auto-clear a capture event zeroes, never reloads
// - Compare select makes the pair the compare value, reload enable ignored
// - Count equal to compare value sets match flag bit 7 of control
// - Match auto-clear zeroes the count after a compare match
// - Capture control and capture result registers reset to zero
// - Reload trigger code 00 overflow, 01 ch0, 10 ch1, 11 ch2
// - Run bit clear halts the count and keeps it; set lets it advance
// - Count advances at clock divided by 4 up to 512, code 000 is 4
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module tcc_top #(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic                      core_clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [ADDR_W-1:0]         paddr_i,
    input  wire logic [tcc_pkg::APB_DW-1:0] pwdata_i,
    input  wire logic [3:0]                pstrb_i,
    output logic      [tcc_pkg::APB_DW-1:0] prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    input  wire logic                      capture_input_0_i,
    input  wire logic                      capture_input_1_i,
    output logic                           capture_irq_o
);
    import tcc_pkg::*;

    typedef struct packed {
        logic [NPIN-1:0]            en;
        logic [NPIN-1:0]            flag;
        logic [2*NPIN-1:0]          esel;
        logic [NPIN-1:0]            fen;
        logic                       crs;
        logic                       run;
        logic                       cmf;
        logic                       len;
        logic [2:0]                 div;
        logic                       cac;
        logic                       mac;
        logic [1:0]                 lts;
        logic                       capture_irq_enable;
        logic                       ea;
        logic [CNT_W-1:0]           rld;
        logic [CNT_W-1:0]           cnt;
        logic [NCH-1:0][CNT_W-1:0]  res;
        logic                       irq;
        logic                       pready;
        logic                       pslverr;
        logic [APB_DW-1:0]          prdata;
    } tcc_top_st_t;

    tcc_top_st_t     st_q;
    tcc_top_st_t     st_d;
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] strobe;
    logic [NPIN-1:0] cap_ev;
    logic            cap_any;
    logic            tick;
    logic            ovf;
    logic            reload_sel;
    logic            reload_ev;
    logic            match;
    logic            rd_phase;
    logic            wr;
    logic            hit;
    logic            addr_ok;
    logic            cnt_wr;
    logic [7:0]      idx;
    logic [7:0]      wb;
    logic [7:0]      rd_byte;

    if (ADDR_W < 11)
    begin : g_chk
        $error("APB address must be at least 11 bits wide");
    end

    assign pins = {capture_input_1_i, capture_input_0_i};

    // Channel 2 has no pin, so only the pinned channels get a detector
    for (genvar g = 0; g < NPIN; g++)
    begin : g_ch
        tcc_chan_if ch ();
        assign ch.raw      = pins[g];
        assign ch.filt_en  = st_q.fen[g];
        assign ch.edge_sel = st_q.esel[2*g +: 2];
        assign strobe[g]   = ch.strobe;
        assign cap_ev[g]   = ch.strobe & st_q.en[g] & ~st_q.crs;
        tcc_edge u_edge (
            .core_clk_i (core_clk_i),
            .reset_i    (reset_i),
            .ch         (ch.det)
        );
    end

    tcc_prescale u_prescale (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .run_i      (st_q.run),
        .div_code_i (st_q.div),
        .tick_o     (tick)
    );

    // Bus decode; one wait state lets read data come from a flop
    always_comb
    begin
        idx = paddr_i[9:2];
        wb = pwdata_i[7:0];
        case (idx)
            IDX_CAP_CTRL, IDX_EDGE_SEL, IDX_FILT, IDX_GIE, IDX_TCTRL,
            IDX_TMODE, IDX_RLD_LO, IDX_RLD_HI, IDX_CNT_LO, IDX_CNT_HI,
            IDX_RES0_LO, IDX_RES0_HI, IDX_RES1_LO, IDX_RES1_HI,
            IDX_IRQ_EN, IDX_RES2_LO, IDX_RES2_HI: hit = 1'b1;
            default:                               hit = 1'b0;
        endcase
        addr_ok = hit && (paddr_i[1:0] == 2'h0)
                  && (paddr_i[ADDR_W-1:10] == '0);
        rd_phase = psel_i && penable_i && !st_q.pready;
        wr = psel_i && penable_i && st_q.pready && pwrite_i
             && pstrb_i[0] && addr_ok;
        cnt_wr = wr && (idx == IDX_CNT_LO || idx == IDX_CNT_HI);
    end

    always_comb
    begin
        rd_byte = 8'h00;
        case (idx)
            IDX_CAP_CTRL:
            begin
                rd_byte[CC_EN_LSB +: NPIN]   = st_q.en;
                rd_byte[CC_FLAG_LSB +: NPIN] = st_q.flag;
            end
            IDX_EDGE_SEL: rd_byte[ES_LSB +: 2*NPIN] = st_q.esel;
            IDX_FILT:     rd_byte[FC_FEN_LSB +: NPIN] = st_q.fen;
            IDX_GIE:      rd_byte[GE_EA_BIT] = st_q.ea;
            IDX_TCTRL:
            begin
                rd_byte[TC_CMF_BIT] = st_q.cmf;
                rd_byte[TC_RUN_BIT] = st_q.run;
                rd_byte[TC_CRS_BIT] = st_q.crs;
            end
            IDX_TMODE:
            begin
                rd_byte[TM_LEN_BIT]      = st_q.len;
                rd_byte[TM_DIV_LSB +: 3] = st_q.div;
                rd_byte[TM_CAC_BIT]      = st_q.cac;
                rd_byte[TM_MAC_BIT]      = st_q.mac;
                rd_byte[TM_LTS_LSB +: 2] = st_q.lts;
            end
            IDX_RLD_LO:  rd_byte = st_q.rld[7:0];
            IDX_RLD_HI:  rd_byte = st_q.rld[15:8];
            IDX_CNT_LO:  rd_byte = st_q.cnt[7:0];
            IDX_CNT_HI:  rd_byte = st_q.cnt[15:8];
            IDX_RES0_LO: rd_byte = st_q.res[0][7:0];
            IDX_RES0_HI: rd_byte = st_q.res[0][15:8];
            IDX_RES1_LO: rd_byte = st_q.res[1][7:0];
            IDX_RES1_HI: rd_byte = st_q.res[1][15:8];
            IDX_RES2_LO: rd_byte = st_q.res[2][7:0];
            IDX_RES2_HI: rd_byte = st_q.res[2][15:8];
            IDX_IRQ_EN:  rd_byte[IE_CPT_BIT] = st_q.capture_irq_enable;
            default:     rd_byte = 8'h00;
        endcase
    end

    // Timer events
    always_comb
    begin
        cap_any = |cap_ev;
        ovf = tick && (st_q.cnt == CNT_MAX);
        case (tcc_rld_t'(st_q.lts))
            TCC_RLD_OVF: reload_sel = ovf;
            TCC_RLD_CH0: reload_sel = cap_ev[0];
            TCC_RLD_CH1: reload_sel = cap_ev[1];
            default:     reload_sel = 1'b0;
        endcase
        reload_ev = ~st_q.crs & st_q.len & reload_sel;
        match = st_q.crs && tick && (st_q.cnt == st_q.rld);
    end

    always_comb
    begin
        st_d = st_q;
        st_d.pready = rd_phase;
        if (rd_phase)
        begin
            st_d.prdata  = {{(APB_DW - 8){1'b0}}, rd_byte};
            st_d.pslverr = !addr_ok;
        end
        if (wr)
        begin
            case (idx)
                IDX_CAP_CTRL:
                begin
                    st_d.en   = wb[CC_EN_LSB +: NPIN];
                    st_d.flag = wb[CC_FLAG_LSB +: NPIN];
                end
                IDX_EDGE_SEL: st_d.esel = wb[ES_LSB +: 2*NPIN];
                IDX_FILT:     st_d.fen = wb[FC_FEN_LSB +: NPIN];
                IDX_GIE:      st_d.ea = wb[GE_EA_BIT];
                IDX_TCTRL:
                begin
                    st_d.cmf = wb[TC_CMF_BIT];
                    st_d.run = wb[TC_RUN_BIT];
                    st_d.crs = wb[TC_CRS_BIT];
                end
                IDX_TMODE:
                begin
                    st_d.len = wb[TM_LEN_BIT];
                    st_d.div = wb[TM_DIV_LSB +: 3];
                    st_d.cac = wb[TM_CAC_BIT];
                    st_d.mac = wb[TM_MAC_BIT];
                    st_d.lts = wb[TM_LTS_LSB +: 2];
                end
                IDX_RLD_LO:  st_d.rld[7:0] = wb;
                IDX_RLD_HI:  st_d.rld[15:8] = wb;
                IDX_RES0_LO: st_d.res[0][7:0] = wb;
                IDX_RES0_HI: st_d.res[0][15:8] = wb;
                IDX_RES1_LO: st_d.res[1][7:0] = wb;
                IDX_RES1_HI: st_d.res[1][15:8] = wb;
                IDX_RES2_LO: st_d.res[2][7:0] = wb;
                IDX_RES2_HI: st_d.res[2][15:8] = wb;
                IDX_IRQ_EN:  st_d.capture_irq_enable = wb[IE_CPT_BIT];
                default:     st_d.capture_irq_enable = st_q.capture_irq_enable;
            endcase
        end
        // Hardware sets after the bus so an edge is never lost to a clear
        for (int i = 0; i < NPIN; i++)
        begin
            if (cap_ev[i])
            begin
                st_d.res[i]  = st_q.cnt;
                st_d.flag[i] = 1'b1;
            end
        end
        if (match)
            st_d.cmf = 1'b1;
        if (cap_any && st_q.cac)
            st_d.cnt = CNT_ZERO;
        else if (reload_ev)
            st_d.cnt = st_q.rld;
        else if (match && st_q.mac)
            st_d.cnt = CNT_ZERO;
        else if (tick)
            st_d.cnt = st_q.cnt + 1'b1;
        // A software write to the count wins over the timer itself
        if (wr && idx == IDX_CNT_LO)
            st_d.cnt[7:0] = wb;
        if (wr && idx == IDX_CNT_HI)
            st_d.cnt[15:8] = wb;
        st_d.irq = (|st_q.flag) && st_q.capture_irq_enable && st_q.ea;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign prdata_o      = st_q.prdata;
    assign pready_o      = st_q.pready;
    assign pslverr_o     = st_q.pslverr;
    assign capture_irq_o = st_q.irq;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    flag_set_a: assert property (cap_ev[1] |=> st_q.flag[1])
        else $error("Capture flag not set after capture edge");
    capture_copy_a: assert property (
        cap_ev[0] |=> st_q.res[0] == $past(st_q.cnt))
        else $error("Result does not hold count at capture edge");
    capture_clear_a: assert property (
        cap_any && st_q.cac && !cnt_wr |=> st_q.cnt == CNT_ZERO)
        else $error("Count not cleared after capture with auto-clear");
    reload_load_a: assert property (
        reload_ev && !(cap_any && st_q.cac) && !cnt_wr
        |=> st_q.cnt == $past(st_q.rld))
        else $error("Count not reloaded on reload event");
    match_flag_a: assert property (
        st_q.crs && tick && st_q.cnt == st_q.rld |=> st_q.cmf)
        else $error("Match flag not set on compare match");
    match_clear_a: assert property (
        match && st_q.mac && !cnt_wr |=> st_q.cnt == CNT_ZERO)
        else $error("Count not cleared after match with auto-clear");
    halt_hold_a: assert property (
        !st_q.run && !cap_any && !cnt_wr |=> $stable(st_q.cnt))
        else $error("Count moved while halted");
    irq_gate_a: assert property (
        ##1 capture_irq_o == $past((|st_q.flag) && st_q.capture_irq_enable && st_q.ea))
        else $error("Interrupt does not follow flags and enables");
    cmp_nocap_a: assert property (st_q.crs |-> !cap_any)
        else $error("Capture in compare mode");
    disabled_ch_a: assert property (!st_q.en[0] |-> !cap_ev[0])
        else $error("Capture on disabled channel");

    capture_cov: cover property (cap_ev[0] ##[1:50] cap_ev[1]);
    reload_cov: cover property (reload_ev && ovf);
    match_cov: cover property (match && st_q.mac);
    apb_cov: cover property (wr ##1 rd_phase);
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the timer capture, reload and compare block
`timescale 1ns/10ps
module tb_top;
    import tcc_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        reset_i    = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0;
    logic [3:0]  pstrb      = 4'h0;
    logic [1:0]  lvl        = 2'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [1:0]  pin;
    logic [32:0] exp_q[$];
    logic [31:0] seed       = 32'hA938;
    logic [15:0] r1         = 16'h0000;
    logic [7:0]  rst_idx[9] = '{IDX_CAP_CTRL, IDX_EDGE_SEL, IDX_FILT,
        IDX_RES0_LO, IDX_RES0_HI, IDX_RES1_LO, IDX_RES1_HI,
        IDX_RES2_LO, IDX_RES2_HI};
    logic        hit;
    int          mismatches = 0;
    int          comparisons = 0;

    always #5 core_clk_i = ~core_clk_i;

    tcc_top #(.ADDR_W(12)) u_tcc_top (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .capture_input_0_i(pin[0]),
        .capture_input_1_i(pin[1]), .capture_irq_o(irq));

    tcc_pin_src u_tcc_pin_src (.core_clk_i(core_clk_i), .lvl_i(lvl),
        .pin_o(pin));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Read results are taken at the completing edge, oldest note first
    always @(posedge core_clk_i)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            if (exp_q.size() == 0)
                mismatches++;
            else
                check({pslverr, prdata}, exp_q.pop_front());
        end

    task automatic xfer(input logic w, input logic [7:0] i,
                        input logic [7:0] d);
        int n;
        @(posedge core_clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'h0, i, 2'h0};
        pwdata  <= {24'h0, d};
        pstrb   <= 4'hF;
        @(posedge core_clk_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            mismatches++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        xfer(1'b1, i, d);
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        exp_q.push_back({1'b0, 24'h0, e});
        xfer(1'b0, i, 8'h00);
    endtask

    task automatic setcnt(input logic [15:0] v);
        wr(IDX_CNT_LO, v[7:0]);
        wr(IDX_CNT_HI, v[15:8]);
    endtask

    // Pin level changes, then enough cycles for sync, filter and capture
    task automatic drive(input int c, input logic v, input int w);
        lvl[c] <= v;
        repeat (w) @(posedge core_clk_i);
    endtask

    initial
    begin
        #100000;
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        foreach (rst_idx[i]) rd(rst_idx[i], 8'h00);
        exp_q.push_back({1'b1, 32'h0});
        xfer(1'b0, 8'h00, 8'h00);
        wr(IDX_RES2_LO, 8'h5A);
        rd(IDX_RES2_LO, 8'h5A);
        setcnt(16'h1234);
        wr(IDX_IRQ_EN, 8'h04);
        wr(IDX_GIE, 8'h80);
        wr(IDX_EDGE_SEL, 8'h01);
        wr(IDX_CAP_CTRL, 8'h10);
        drive(0, 1'b1, 12);
        rd(IDX_RES0_LO, 8'h34);
        rd(IDX_RES0_HI, 8'h12);
        rd(IDX_CAP_CTRL, 8'h11);
        check({32'h0, irq}, 33'h1);
        wr(IDX_IRQ_EN, 8'h00);
        repeat (3) @(posedge core_clk_i);
        check({32'h0, irq}, 33'h0);
        wr(IDX_IRQ_EN, 8'h04);
        wr(IDX_CAP_CTRL, 8'h10);
        repeat (3) @(posedge core_clk_i);
        check({32'h0, irq}, 33'h0);
        drive(0, 1'b0, 12);
        rd(IDX_CAP_CTRL, 8'h10);
        // Every edge code on channel 1, then a disabled channel
        for (int k = 0; k < 5; k++)
        begin
            seed = nxt(seed);
            setcnt(seed[15:0]);
            wr(IDX_EDGE_SEL, (k == 4) ? 8'h08 : 8'(k << 2));
            wr(IDX_CAP_CTRL, (k == 4) ? 8'h00 : 8'h20);
            for (int e = 0; e < 2; e++)
            begin
                drive(1, e == 0, 12);
                hit = (k == 2) || (k == 1 - e);
                if (hit)
                    r1 = seed[15:0];
                rd(IDX_CAP_CTRL, {2'h0, k < 4, 3'h0, hit, 1'b0});
                rd(IDX_RES1_LO, r1[7:0]);
                rd(IDX_RES1_HI, r1[15:8]);
                wr(IDX_CAP_CTRL, (k == 4) ? 8'h00 : 8'h20);
            end
        end
        // Switching the filter may leave one stray edge, so clear after
        wr(IDX_EDGE_SEL, 8'h01);
        wr(IDX_FILT, 8'h10);
        repeat (12) @(posedge core_clk_i);
        wr(IDX_CAP_CTRL, 8'h10);
        drive(0, 1'b1, 2);
        drive(0, 1'b0, 16);
        rd(IDX_CAP_CTRL, 8'h10);
        drive(0, 1'b1, 16);
        rd(IDX_CAP_CTRL, 8'h11);
        drive(0, 1'b0, 16);
        wr(IDX_FILT, 8'h00);
        wr(IDX_RLD_LO, 8'hCD);
        wr(IDX_RLD_HI, 8'hAB);
        wr(IDX_TMODE, 8'h89);
        setcnt(16'h1234);
        drive(0, 1'b1, 12);
        rd(IDX_RES0_LO, 8'h34);
        rd(IDX_CNT_LO, 8'h00);
        rd(IDX_CNT_HI, 8'h00);
        wr(IDX_TMODE, 8'h81);
        drive(0, 1'b0, 12);
        drive(0, 1'b1, 12);
        rd(IDX_CNT_LO, 8'hCD);
        rd(IDX_CNT_HI, 8'hAB);
        wr(IDX_TMODE, 8'h82);
        setcnt(16'h0042);
        drive(0, 1'b0, 12);
        drive(0, 1'b1, 12);
        rd(IDX_CNT_LO, 8'h42);
        wr(IDX_TMODE, 8'h80);
        wr(IDX_RLD_HI, 8'h12);
        setcnt(16'hFFFF);
        wr(IDX_TCTRL, 8'h04);
        repeat (8) @(posedge core_clk_i);
        wr(IDX_TCTRL, 8'h00);
        rd(IDX_CNT_HI, 8'h12);
        rd(IDX_CNT_LO, 8'hCF);
        // Compare mode with reload enable still set
        wr(IDX_TMODE, 8'h84);
        wr(IDX_RLD_LO, 8'h00);
        wr(IDX_RLD_HI, 8'h01);
        setcnt(16'h0000);
        wr(IDX_CAP_CTRL, 8'h10);
        wr(IDX_TCTRL, 8'h05);
        drive(0, 1'b0, 12);
        drive(0, 1'b1, 1100);
        rd(IDX_TCTRL, 8'h85);
        wr(IDX_TCTRL, 8'h01);
        rd(IDX_TCTRL, 8'h01);
        rd(IDX_CNT_HI, 8'h00);
        rd(IDX_CAP_CTRL, 8'h10);
        repeat (2) @(posedge core_clk_i);
        if (exp_q.size() != 0)
            mismatches++;
        report_and_stop();
    end
endmodule

/* verification/tcc_pin_src.sv */
// Model of the external sources that drive the two capture pins
`timescale 1ns/10ps
module tcc_pin_src (
    input  wire logic       core_clk_i,
    input  wire logic [1:0] lvl_i,
    output logic      [1:0] pin_o
);
    // Levels move just after an edge; the pins are registered on the block clock core_clk_i
    always_ff @(posedge core_clk_i)
        pin_o <= lvl_i;
endmodule
